/* shared/fsp_defines.svh */
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FSP_OFS_CTRL 4'h0
`define FSP_OFS_PTR 4'h4
`define FSP_OFS_SPACE 4'h8
`define FSP_OFS_STATUS 4'hC

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define FSP_BIT_WORDSEL 5
`define FSP_BIT_ERASE 4
`define FSP_BIT_ERR 3
`define FSP_BIT_WEN 2
`define FSP_BIT_START 1

// ----------------------------------------------------------------
// Space select and status field positions
// ----------------------------------------------------------------
`define FSP_BIT_MEMSEL 0
`define FSP_BIT_CFGSEL 1
`define FSP_BIT_BUSY 0

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define FSP_PTR_W 22
`define FSP_PTR_RST 22'h000000
`define FSP_BYTES_WORD 7'h02
`define FSP_BYTES_ROW 7'h40

// ----------------------------------------------------------------
// Self-timed durations, in ns, and derived cycle counts
// ----------------------------------------------------------------
`define FSP_CLK_NS 20
`define FSP_ERASE_NS 2000
`define FSP_WORD_NS 400
`define FSP_ROW_NS 1600
`define FSP_ERASE_CYC ((`FSP_ERASE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WORD_CYC ((`FSP_WORD_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_ROW_CYC ((`FSP_ROW_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

/* shared/fsp_pkg.sv */
`include "fsp_defines.svh"

package fsp_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_LAUNCH = 2'b01,
    FSP_WAIT = 2'b11,
    FSP_FINISH = 2'b10
  } fsp_state_e;

  // ----------------------------------------------------------------
  // Command toward the flash array
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic erase;
    logic [6:0] bytes;
    logic [`FSP_PTR_W-1:0] addr;
  } fsp_cmd_s;

  // ----------------------------------------------------------------
  // Accepted bus access handed to the register file
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } fsp_bus_s;

endpackage

/* rtl/fsp_avalon_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module fsp_avalon_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic sysRst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Register file side
  output fsp_pkg::fsp_bus_s busReq,
  input wire logic [31:0] rdWord
);

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  logic waitReq_r; // High except in the answering cycle
  logic [31:0] rdData_r; // Captured read word
  wire accept = (avs_read | avs_write) & waitReq_r;

  // One wait cycle per access; the answer cycle drops waitrequest
  always_ff @(posedge clk) begin
    if (sysRst) begin
      waitReq_r <= 1'b1;
      rdData_r <= 32'h00000000;
    end else begin
      waitReq_r <= ~accept;
      rdData_r <= (accept & avs_read) ? rdWord : 32'h00000000;
    end
  end

  // Strobes fire at the edge where the master sees waitrequest low
  assign busReq.wr = avs_write & ~waitReq_r;
  assign busReq.rd = avs_read & ~waitReq_r;
  assign busReq.addr = avs_address;
  assign busReq.wdata = avs_writedata;
  assign avs_readdata = rdData_r;
  assign avs_waitrequest = waitReq_r;

endmodule

`default_nettype wire

/* rtl/fsp_op_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module fsp_op_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sysRst,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] loadVal,
  // Status
  output logic done,
  output logic running
);

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_r; // Cycles still to run
  logic done_r; // Completion pulse
  wire last = (count_r == {{(CNT_W-1){1'b0}}, 1'b1});

  // A zero load would hang, so it is treated as one cycle
  always_ff @(posedge clk) begin
    if (sysRst) begin
      count_r <= '0;
      done_r <= 1'b0;
    end else if (load) begin
      count_r <= (loadVal == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : loadVal;
      done_r <= 1'b0;
    end else begin
      done_r <= last;
      count_r <= (count_r == '0) ? count_r : count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign done = done_r;
  assign running = (count_r != '0);

endmodule

`default_nettype wire

/* rtl/fsp_flash_self_program.sv */
// Operation
// - Control bits sit at positions five to one
// - Bits 7, 6 and 0 read zero
// - Word select picks 2 or 64 bytes
// - Erase enable erases the pointed row
// - Erase enable clears after erase completes
// - Improper or reset-cut write sets error flag
// - Error flag zero after normal completion
// - Write enable low blocks all cycles
// - Start bit launches erase or write
// - Hardware clears start bit when finished
// - Software cannot clear the start bit
// - Space selects survive an error
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"

module fsp_flash_self_program #(
  parameter int PTR_W = `FSP_PTR_W,
  parameter int CNT_W = 16,
  parameter int ERASE_CYCLES = `FSP_ERASE_CYC,
  parameter int WORD_CYCLES = `FSP_WORD_CYC,
  parameter int ROW_CYCLES = `FSP_ROW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sysRst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash array side
  input wire logic flashAborted,
  output fsp_pkg::fsp_cmd_s flashCmd,
  output logic flashBusy
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  fsp_pkg::fsp_bus_s busReq; // Accepted access
  logic [31:0] rdWord; // Word for the addressed register

  fsp_avalon_slave u_slave (
    .clk(clk),
    .sysRst(sysRst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .busReq(busReq),
    .rdWord(rdWord)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic wordSel_r; // Word-wide program select
  logic rowErase_r; // Row erase enable
  logic errFlag_r; // Program error flag
  logic writeEn_r; // Program write enable
  logic start_r; // Start control, set-only
  logic memSel_r; // Memory space select
  logic cfgSel_r; // Configuration space select
  logic [PTR_W-1:0] tablePtr_r; // Table pointer
  logic postRst_r; // First cycle after reset release
  fsp_pkg::fsp_state_e state_r; // Sequencer state
  fsp_pkg::fsp_state_e state_nxt; // Next sequencer state
  fsp_pkg::fsp_cmd_s cmd_r; // Registered array command
  logic busy_r; // Operation in flight
  logic opErase_r; // Latched kind of the running cycle

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hitReg(input logic [3:0] a, input logic [3:0] ofs);
    hitReg = (a == ofs);
  endfunction

  wire ctrlWr = busReq.wr & hitReg(busReq.addr, `FSP_OFS_CTRL);
  wire ptrWr = busReq.wr & hitReg(busReq.addr, `FSP_OFS_PTR);
  wire spaceWr = busReq.wr & hitReg(busReq.addr, `FSP_OFS_SPACE);
  wire [31:0] wd = busReq.wdata;

  // Start requested by software; a set while already running is a no-op
  wire startWr = ctrlWr & wd[`FSP_BIT_START] & ~start_r;
  // Enable bit as it stands after this write
  wire enNew = wd[`FSP_BIT_WEN];
  // Starting without write enable is an improper attempt
  wire improper = startWr & ~enNew;
  wire launchOk = startWr & enNew;
  // Cycle cut short by a reset, reported by the array after release
  wire resetCut = postRst_r & flashAborted;
  wire finishing = (state_r == fsp_pkg::FSP_FINISH);
  wire timerDone;

  // Mode bits are frozen while busy so the running cycle stays coherent
  wire modeWr = ctrlWr & ~busy_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] ctrlWord = {2'b00, wordSel_r, rowErase_r, errFlag_r, writeEn_r,
                         start_r, 1'b0};
  wire [31:0] ptrWord = {{(32-PTR_W){1'b0}}, tablePtr_r};
  wire [31:0] spaceWord = {30'h00000000, cfgSel_r, memSel_r};
  wire [31:0] statusWord = {29'h00000000, state_r, busy_r};

  // Unmapped offsets read as zero and ignore writes
  assign rdWord =
    hitReg(busReq.addr, `FSP_OFS_CTRL) ? {24'h000000, ctrlWord} :
    hitReg(busReq.addr, `FSP_OFS_PTR) ? ptrWord :
    hitReg(busReq.addr, `FSP_OFS_SPACE) ? spaceWord :
    hitReg(busReq.addr, `FSP_OFS_STATUS) ? statusWord :
    32'h00000000;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Mode and enable bits follow software writes
  always_ff @(posedge clk) begin
    if (sysRst) begin
      wordSel_r <= 1'b0;
      writeEn_r <= 1'b0;
    end else if (modeWr) begin
      wordSel_r <= wd[`FSP_BIT_WORDSEL];
      writeEn_r <= wd[`FSP_BIT_WEN];
    end
  end

  // Erase enable: software sets it, completion of an erase clears it
  always_ff @(posedge clk) begin
    if (sysRst) begin
      rowErase_r <= 1'b0;
    end else if (finishing & opErase_r) begin
      rowErase_r <= 1'b0;
    end else if (modeWr) begin
      rowErase_r <= wd[`FSP_BIT_ERASE];
    end
  end

  // Start bit: set only by software, cleared only by completion
  always_ff @(posedge clk) begin
    if (sysRst) begin
      start_r <= 1'b0;
    end else if (launchOk) begin
      start_r <= 1'b1;
    end else if (finishing) begin
      start_r <= 1'b0;
    end
  end

  // Error flag: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (sysRst) begin
      errFlag_r <= 1'b0;
    end else if (improper | resetCut) begin
      errFlag_r <= 1'b1;
    end else if (finishing) begin
      errFlag_r <= 1'b0;
    end else if (ctrlWr) begin
      errFlag_r <= wd[`FSP_BIT_ERR];
    end
  end

  // Reset-release marker for catching an interrupted cycle
  always_ff @(posedge clk) begin
    if (sysRst) begin
      postRst_r <= 1'b1;
    end else begin
      postRst_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pointer and space selects
  // ----------------------------------------------------------------
  // The pointer is held steady while the array uses it
  always_ff @(posedge clk) begin
    if (sysRst) begin
      tablePtr_r <= `FSP_PTR_RST;
    end else if (ptrWr & ~busy_r) begin
      tablePtr_r <= wd[PTR_W-1:0];
    end
  end

  // Errors never touch these, so the failing target stays visible
  always_ff @(posedge clk) begin
    if (sysRst) begin
      memSel_r <= 1'b0;
      cfgSel_r <= 1'b0;
    end else if (spaceWr) begin
      memSel_r <= wd[`FSP_BIT_MEMSEL];
      cfgSel_r <= wd[`FSP_BIT_CFGSEL];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Idle waits for start, launch issues, wait runs the timer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fsp_pkg::FSP_IDLE: begin
        if (start_r) begin
          state_nxt = fsp_pkg::FSP_LAUNCH;
        end
      end
      fsp_pkg::FSP_LAUNCH: begin
        state_nxt = fsp_pkg::FSP_WAIT;
      end
      fsp_pkg::FSP_WAIT: begin
        if (timerDone) begin
          state_nxt = fsp_pkg::FSP_FINISH;
        end
      end
      default: begin
        state_nxt = fsp_pkg::FSP_IDLE;
      end
    endcase
  end

  wire launching = (state_r == fsp_pkg::FSP_LAUNCH);
  wire [CNT_W-1:0] eraseLen = CNT_W'(ERASE_CYCLES);
  wire [CNT_W-1:0] wordLen = CNT_W'(WORD_CYCLES);
  wire [CNT_W-1:0] rowLen = CNT_W'(ROW_CYCLES);
  // Duration follows the kind of cycle
  wire [CNT_W-1:0] opLen = rowErase_r ? eraseLen : (wordSel_r ? wordLen : rowLen);
  wire [6:0] opBytes = wordSel_r ? `FSP_BYTES_WORD : `FSP_BYTES_ROW;

  // State, busy and latched kind
  always_ff @(posedge clk) begin
    if (sysRst) begin
      state_r <= fsp_pkg::FSP_IDLE;
      busy_r <= 1'b0;
      opErase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Start is still high in the finish cycle, so it must not hold busy up
      busy_r <= (state_nxt != fsp_pkg::FSP_IDLE) | (start_r & ~finishing) | launchOk;
      if (launching) begin
        opErase_r <= rowErase_r;
      end
    end
  end

  // One-cycle command pulse to the array
  always_ff @(posedge clk) begin
    if (sysRst) begin
      cmd_r <= '0;
    end else begin
      cmd_r.valid <= launching;
      cmd_r.erase <= launching & rowErase_r;
      cmd_r.bytes <= launching ? opBytes : 7'h00;
      cmd_r.addr <= launching ? tablePtr_r : '0;
    end
  end

  // ----------------------------------------------------------------
  // Self timing
  // ----------------------------------------------------------------
  fsp_op_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clk(clk),
    .sysRst(sysRst),
    .load(launching),
    .loadVal(opLen),
    .done(timerDone),
    .running()
  );

  assign flashCmd = cmd_r;
  assign flashBusy = busy_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_unimpl_zero: assert property (@(posedge clk) disable iff (sysRst)
    (busReq.rd && busReq.addr == `FSP_OFS_CTRL) |->
      (avs_readdata[7:6] == 2'b00 && avs_readdata[0] == 1'b0))
    else $error("unimplemented control bits read nonzero");

  a_layout_mode: assert property (@(posedge clk) disable iff (sysRst)
    modeWr |=> (wordSel_r == $past(wd[5]) && writeEn_r == $past(wd[2])))
    else $error("control bits not at their positions");

  a_byte_count: assert property (@(posedge clk) disable iff (sysRst)
    launching |=> (flashCmd.bytes == ($past(wordSel_r) ? 7'h02 : 7'h40)))
    else $error("programmed byte count wrong");

  a_erase_kind: assert property (@(posedge clk) disable iff (sysRst)
    flashCmd.valid |-> (flashCmd.erase == $past(rowErase_r)))
    else $error("erase versus write chosen wrongly");

  a_erase_clear: assert property (@(posedge clk) disable iff (sysRst)
    (finishing && opErase_r) |=> !rowErase_r)
    else $error("erase enable not cleared after erase");

  a_write_only: assert property (@(posedge clk) disable iff (sysRst)
    (launching && !rowErase_r) |=> (flashCmd.valid && !flashCmd.erase))
    else $error("erase issued without erase enable");

  a_improper_err: assert property (@(posedge clk) disable iff (sysRst)
    improper |=> (errFlag_r && !start_r && !flashCmd.valid))
    else $error("improper start not flagged");

  a_done_noerr: assert property (@(posedge clk) disable iff (sysRst)
    (finishing && !resetCut && !improper) |=> !errFlag_r)
    else $error("error flag set after normal completion");

  a_enable_gate: assert property (@(posedge clk) disable iff (sysRst)
    $rose(start_r) |-> $past(enNew && ctrlWr))
    else $error("cycle started without write enable");

  a_start_launch: assert property (@(posedge clk) disable iff (sysRst)
    $rose(start_r) |-> ##2 (flashCmd.valid && flashBusy))
    else $error("start did not launch a cycle");

  a_start_clear: assert property (@(posedge clk) disable iff (sysRst)
    timerDone |=> finishing ##1 (!start_r && !flashBusy))
    else $error("start bit not cleared at completion");

  a_set_only: assert property (@(posedge clk) disable iff (sysRst)
    (start_r && !finishing) |=> start_r)
    else $error("start bit cleared by software");

  a_space_kept: assert property (@(posedge clk) disable iff (sysRst)
    ($rose(errFlag_r) && !$past(spaceWr)) |-> ($stable(memSel_r) && $stable(cfgSel_r)))
    else $error("space selects changed on error");

endmodule

`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // Short self-timed counts so each operation fits a few bus accesses
  // ----------------------------------------------------------------
  localparam int WORD_N = 12;
  localparam int ROW_N = 16;
  localparam int ERASE_N = 20;

  logic clk; // 50 MHz core clock
  logic sysRst; // Synchronous reset
  logic [3:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic flashAborted; // Array reports a cut cycle
  fsp_pkg::fsp_cmd_s flashCmd;
  logic flashBusy;
  fsp_pkg::fsp_cmd_s cmdQ[$]; // Every command pulse seen
  int busyLen; // Length of the running busy window
  int lastLen; // Length of the last finished busy window
  int badCount;
  int checks;
  logic [31:0] seed; // Stimulus state

  fsp_flash_self_program #(
    .WORD_CYCLES(WORD_N),
    .ROW_CYCLES(ROW_N),
    .ERASE_CYCLES(ERASE_N)
  ) u_fsp_flash_self_program (
    .clk(clk),
    .sysRst(sysRst),
    .avs_address(avsAddress),
    .avs_read(avsRead),
    .avs_write(avsWrite),
    .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest),
    .flashAborted(flashAborted),
    .flashCmd(flashCmd),
    .flashBusy(flashBusy)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Array-side monitor: values sampled before the edge updates land
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (flashCmd.valid === 1'b1) begin
      cmdQ.push_back(flashCmd);
    end
    if (flashBusy === 1'b1) begin
      busyLen++;
    end else if (busyLen != 0) begin
      lastLen = busyLen;
      busyLen = 0;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Verdict and end of run, the single exit point
  task automatic wrapUp();
    if (badCount == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compare one design value with the model value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [3:0] addr,
                          input logic [31:0] data, output logic [31:0] rd);
    int n;
    avsAddress <= addr;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= data;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      badCount++;
      wrapUp();
    end
    // One idle edge so the next request never overlaps this release
    @(posedge clk);
  endtask

  // Read a register and compare it with the model
  task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, addr, 32'h0000_0000, rd);
    check(rd, exp);
  endtask

  // ----------------------------------------------------------------
  // One started operation, with set-only start tried in mid-flight
  // ----------------------------------------------------------------
  task automatic run_op(input logic [7:0] cv);
    logic [31:0] rd;
    logic [31:0] ptr;
    int n;
    int expLen;
    seed = lfsr_next(seed);
    ptr = {10'h000, seed[21:0]};
    // Expected busy time: start, launch, N+1 cycles up to the done pulse, finish
    expLen = (cv[4] ? ERASE_N : (cv[5] ? WORD_N : ROW_N)) + 4;
    bus_xfer(1'b1, 4'h4, ptr, rd);
    cmdQ.delete();
    lastLen = 0;
    bus_xfer(1'b1, 4'h0, {24'h00_0000, cv}, rd);
    n = 0;
    while (flashBusy !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      badCount++;
      wrapUp();
    end
    rd_chk(4'h0, {24'h00_0000, cv & 8'h36});
    // Try to clear start and set the error flag by software
    bus_xfer(1'b1, 4'h0, {24'h00_0000, (cv & 8'hFD) | 8'h08}, rd);
    rd_chk(4'h0, {24'h00_0000, (cv & 8'h36) | 8'h08});
    // Status in the middle of the self-timed wait: wait state, busy
    rd_chk(4'hC, 32'h0000_0007);
    n = 0;
    while (lastLen == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      badCount++;
      wrapUp();
    end
    check(32'(lastLen), 32'(expLen));
    check(32'(cmdQ.size()), 32'h0000_0001);
    if (cmdQ.size() > 0) begin
      check(32'(cmdQ[0].erase), 32'(cv[4]));
      check(32'(cmdQ[0].addr), ptr);
      if (!cv[4]) begin
        check(32'(cmdQ[0].bytes), cv[5] ? 32'h0000_0002 : 32'h0000_0040);
      end
    end
    // Start and error clear at finish, erase enable drops after an erase
    rd_chk(4'h0, {24'h00_0000, cv & 8'h24});
    rd_chk(4'hC, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [7:0] ops[4];
    sysRst = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0000_0000;
    flashAborted = 1'b1;
    busyLen = 0;
    lastLen = 0;
    badCount = 0;
    checks = 0;
    seed = 32'h6905;
    ops = '{8'h26, 8'h06, 8'h16, 8'h36};
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    // Array reported a cut cycle through the first cycle after reset
    flashAborted <= 1'b0;
    @(posedge clk);
    rd_chk(4'h0, 32'h0000_0008);
    bus_xfer(1'b1, 4'h0, 32'h0000_0000, rd);
    rd_chk(4'h0, 32'h0000_0000);
    // Unimplemented bits stay zero, no start requested here
    bus_xfer(1'b1, 4'h0, 32'h0000_00E5, rd);
    rd_chk(4'h0, 32'h0000_0024);
    rd_chk(4'h2, 32'h0000_0000);
    bus_xfer(1'b1, 4'h8, 32'h0000_0003, rd);
    rd_chk(4'h8, 32'h0000_0003);
    // Improper attempt: start with write enable low in the same word
    cmdQ.delete();
    lastLen = 0;
    bus_xfer(1'b1, 4'h0, 32'h0000_0022, rd);
    rd_chk(4'h0, 32'h0000_0028);
    check(32'(cmdQ.size()), 32'h0000_0000);
    check(32'(lastLen + busyLen), 32'h0000_0000);
    rd_chk(4'h8, 32'h0000_0003);
    // Word program, row program, erase, erase with word select
    foreach (ops[i]) begin
      run_op(ops[i]);
    end
    wrapUp();
  end
endmodule

`default_nettype wire
